// ===== src/hbi_host_bus.sv
`timescale 1ns/1ps
`default_nettype none

// Three-stage pin synchroniser; a new level is taken once stages two and three agree.
module hbi_sync3 #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_reset_n,
    input  wire logic [W-1:0] i_d,
    output var  logic [W-1:0] o_q
);
    logic [W-1:0] s1_reg;  // Metastable stage, read only by s2_reg.
    logic [W-1:0] s2_reg;  // Second stage.
    logic [W-1:0] s3_reg;  // Third stage.

    // Per bit, the filtered level moves only when the two settled stages agree.
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s1_reg <= '1;
            s2_reg <= '1;
            s3_reg <= '1;
            o_q    <= '1;
        end else begin
            s1_reg <= i_d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            for (int b = 0; b < W; b++) begin
                if (s2_reg[b] == s3_reg[b]) begin
                    o_q[b] <= s2_reg[b];
                end
            end
        end
    end
endmodule

// Host bus port with both bus variants, daisy chain, ports and one timer source.
module hbi_host_bus (
    input  wire logic       I_CLK,
    input  wire logic       I_RESET_N,
    input  wire logic       I_MUXED_MODE,
    input  wire logic       I_ADDR_STROBE_N,
    input  wire logic       I_DATA_STROBE_N,
    input  wire logic       I_READ_HIGH,
    input  wire logic       I_SELECT_LOW_N,
    input  wire logic       I_SELECT_HIGH,
    input  wire logic       I_RD_N,
    input  wire logic       I_WR_N,
    input  wire logic       I_CHIP_SEL_N,
    input  wire logic [1:0] I_ADDR,
    input  wire logic       I_VECTOR_ACK_IN_N,
    input  wire logic       I_CHAIN_ENABLE_IN,
    input  wire logic [7:0] I_BUS_LINES,
    output var  logic [7:0] O_BUS_LINES,
    output var  logic       O_BUS_OE,
    input  wire logic       I_IRQ_N,
    output var  logic       O_IRQ_N,
    output var  logic       O_IRQ_OE,
    output var  logic       O_CHAIN_ENABLE_OUT,
    input  wire logic [7:0] I_FIRST_PORT_LINES,
    output var  logic [7:0] O_FIRST_PORT_LINES,
    output var  logic [7:0] O_FIRST_PORT_OE,
    input  wire logic [7:0] I_SECOND_PORT_LINES,
    output var  logic [7:0] O_SECOND_PORT_LINES,
    output var  logic [7:0] O_SECOND_PORT_OE,
    input  wire logic [3:0] I_HANDSHAKE_PORT_LINES,
    output var  logic [3:0] O_HANDSHAKE_PORT_LINES,
    output var  logic [3:0] O_HANDSHAKE_PORT_OE
);
    logic [12:0] ctl_s;           // Synchronised strobes, selects and mode.
    logic [7:0]  bus_s;           // Synchronised bus lines.
    logic [19:0] port_s;          // Synchronised port inputs.
    logic        as_n, ds_n, rw_high, sel_lo_n, sel_hi, rd_n, wr_n, ce_n;
    logic        ack_n, chain_in, muxed;
    logic [1:0]  addr_pins;
    logic        ds_prev_reg;     // Previous data strobe level.
    logic        rd_prev_reg;     // Previous read strobe level.
    logic        wr_prev_reg;     // Previous write strobe level.
    logic [5:0]  maddr_reg;       // Latched muxed register address.
    logic        msel_reg;        // Latched muxed select.
    logic        mack_reg;        // Latched muxed acknowledge, high when active.
    logic [5:0]  ptr_reg;         // Control pointer.
    hbi_pkg::hbi_state_t state_reg;
    logic [7:0]  regs [64];       // Control space storage.
    logic        pending_flag;    // Interrupt pending.
    logic        in_service_flag; // Interrupt under service.
    logic [7:0]  timer_reg;       // Down counter.
    logic        timer_pin_reg;   // Toggles each time the counter expires.
    hbi_pkg::hbi_access_t acc;    // Decoded access of this cycle.
    logic        ctrl_sel;        // Non-muxed access names the control path.
    logic        ptr_load;        // This write loads the pointer.
    logic        strobe_reset;    // Illegal strobe pair seen.
    logic        in_reset;        // Reset bit of master control.
    logic        ack_active;      // An acknowledge cycle is under way.
    logic        win;             // This device answers the acknowledge.
    logic        timer_zero;      // Counter expiry event.
    logic        strobe_idle;     // Muxed data strobe or non-muxed read strobe released.
    logic [7:0]  rdata;           // Read data for acc.addr.
    logic        exists;          // acc.addr names a register.

    hbi_sync3 #(.W(13)) u_sync_ctl (
        .i_clk     (I_CLK),
        .i_reset_n (I_RESET_N),
        .i_d       ({I_MUXED_MODE, I_ADDR_STROBE_N, I_DATA_STROBE_N, I_READ_HIGH,
                     I_SELECT_LOW_N, I_SELECT_HIGH, I_RD_N, I_WR_N, I_CHIP_SEL_N,
                     I_ADDR, I_VECTOR_ACK_IN_N, I_CHAIN_ENABLE_IN}),
        .o_q       (ctl_s)
    );
    hbi_sync3 #(.W(8)) u_sync_bus (
        .i_clk     (I_CLK),
        .i_reset_n (I_RESET_N),
        .i_d       (I_BUS_LINES),
        .o_q       (bus_s)
    );
    hbi_sync3 #(.W(20)) u_sync_port (
        .i_clk     (I_CLK),
        .i_reset_n (I_RESET_N),
        .i_d       ({I_HANDSHAKE_PORT_LINES, I_SECOND_PORT_LINES, I_FIRST_PORT_LINES}),
        .o_q       (port_s)
    );

    assign {muxed, as_n, ds_n, rw_high, sel_lo_n, sel_hi, rd_n, wr_n, ce_n,
            addr_pins, ack_n, chain_in} = ctl_s;
    assign in_reset    = regs[hbi_pkg::MASTER_CTRL_ADDR][hbi_pkg::MC_RESET_BIT];
    assign strobe_idle = muxed ? ds_n : rd_n;
    assign ack_active  = muxed ? mack_reg : !ack_n;

    // Illegal strobe pairs act as a reset of the whole block.
    assign strobe_reset = muxed ? (!as_n && !ds_n)     // [RQ4]
                                : (!rd_n && !wr_n);    // [RQ12]

    // Strobe history for edge detection.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ds_prev_reg <= 1'b1;
            rd_prev_reg <= 1'b1;
            wr_prev_reg <= 1'b1;
        end else begin
            ds_prev_reg <= ds_n;
            rd_prev_reg <= rd_n;
            wr_prev_reg <= wr_n;
        end
    end

    // While the address strobe is low the muxed address phase is tracked; the last
    // value seen before it rises stays latched for the data phase.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            maddr_reg <= 6'h00;
            msel_reg  <= 1'b0;
            mack_reg  <= 1'b0;
        end else if (muxed && !as_n && ds_n) begin
            msel_reg <= !sel_lo_n && sel_hi;                  // [RQ1]
            mack_reg <= !ack_n;                               // [RQ1]
            maddr_reg <= regs[hbi_pkg::MASTER_CTRL_ADDR][hbi_pkg::MC_ALIGN_BIT]
                       ? bus_s[5:0] : bus_s[6:1];             // [RQ5] [RQ24]
        end
    end

    // Decode one access per strobe fall, in either variant.
    always_comb begin
        acc      = '0;
        ctrl_sel = 1'b0;
        ptr_load = 1'b0;
        acc.data = bus_s;
        if (muxed) begin
            // The data strobe fall times the transfer; direction picks read or write.
            if (!ds_n && ds_prev_reg && !as_n == 1'b0) begin // [RQ2]
                acc.ack  = mack_reg;
                acc.rd   = msel_reg && !mack_reg && rw_high;  // [RQ3]
                acc.wr   = msel_reg && !mack_reg && !rw_high; // [RQ3]
                acc.addr = maddr_reg;
            end
        end else begin
            acc.ack  = !rd_n && rd_prev_reg && !ack_n;
            acc.rd   = !rd_n && rd_prev_reg && ack_n && !ce_n;  // [RQ11] [RQ13]
            acc.wr   = !wr_n && wr_prev_reg && !ce_n;           // [RQ11] [RQ14]
            ctrl_sel = (addr_pins == hbi_pkg::SEL_CTRL);
            case (addr_pins)                                    // [RQ22]
                hbi_pkg::SEL_HS:     acc.addr = hbi_pkg::HS_DATA_ADDR;
                hbi_pkg::SEL_SECOND: acc.addr = hbi_pkg::SECOND_DATA_ADDR;
                hbi_pkg::SEL_FIRST:  acc.addr = hbi_pkg::FIRST_DATA_ADDR;
                default:             acc.addr = ptr_reg;
            endcase
            // In reset the pointer is pinned to master control, so a control write
            // goes straight there; otherwise the reset bit could never be cleared.
            ptr_load = ctrl_sel && acc.wr && !in_reset
                       && (state_reg == hbi_pkg::ST_POINTER);  // [RQ23]
        end
    end

    // Only listed offsets exist; data registers read the live port lines.
    always_comb begin
        exists = 1'b1;
        rdata  = regs[acc.addr];
        case (acc.addr)
            hbi_pkg::FIRST_DATA_ADDR:  rdata = port_s[7:0];
            hbi_pkg::SECOND_DATA_ADDR: rdata = port_s[15:8];
            hbi_pkg::HS_DATA_ADDR:     rdata = {4'h0, port_s[19:16]};
            hbi_pkg::MASTER_CTRL_ADDR, hbi_pkg::CONFIG_ADDR, hbi_pkg::VECTOR_ADDR,
            hbi_pkg::HS_DIR_ADDR, hbi_pkg::COMMAND_ADDR, hbi_pkg::TIMER_LOAD_ADDR,
            hbi_pkg::FIRST_DIR_ADDR, hbi_pkg::SECOND_DIR_ADDR: rdata = regs[acc.addr];
            default:                   exists = 1'b0;
        endcase
        if (in_reset) begin
            rdata = hbi_pkg::RESET_READ_VAL;
        end
    end

    // A device that loses the acknowledge neither drives the bus nor marks service.
    assign win = acc.ack && chain_in && pending_flag && !in_service_flag;  // [RQ25]

    // Two-step control state; any control read returns it to the pointer step.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state_reg <= hbi_pkg::ST_POINTER;
            ptr_reg   <= hbi_pkg::MASTER_CTRL_ADDR;
        end else if (strobe_reset || in_reset) begin
            state_reg <= hbi_pkg::ST_POINTER;
            ptr_reg   <= hbi_pkg::MASTER_CTRL_ADDR;
        end else if (!muxed && ctrl_sel && (acc.rd || acc.wr)) begin
            case (state_reg)                                  // [RQ23]
                hbi_pkg::ST_POINTER: begin
                    if (ptr_load) begin
                        ptr_reg   <= acc.data[5:0];
                        state_reg <= hbi_pkg::ST_TARGET;
                    end
                end
                hbi_pkg::ST_TARGET: state_reg <= hbi_pkg::ST_POINTER;
                default:            state_reg <= hbi_pkg::ST_POINTER;
            endcase
        end
    end

    // Register writes; in reset only the reset bit may be written.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            for (int i = 0; i < 64; i++) begin
                regs[i] <= hbi_pkg::REG_RESET_VAL;
            end
            regs[hbi_pkg::MASTER_CTRL_ADDR] <= hbi_pkg::MC_RESET_VAL;
        end else if (strobe_reset) begin
            for (int i = 0; i < 64; i++) begin
                regs[i] <= hbi_pkg::REG_RESET_VAL;
            end
            regs[hbi_pkg::MASTER_CTRL_ADDR] <= hbi_pkg::MC_RESET_VAL;  // [RQ4] [RQ12]
        end else if (acc.wr && !ptr_load && exists) begin
            if (in_reset) begin
                if (acc.addr == hbi_pkg::MASTER_CTRL_ADDR) begin
                    regs[hbi_pkg::MASTER_CTRL_ADDR] <= {7'h00, acc.data[0]};
                end
            end else begin
                regs[acc.addr] <= acc.data;                   // [RQ14]
            end
        end
    end

    // Timer on the block clock; expiry is the interrupt source.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            timer_reg     <= 8'h00;
            timer_pin_reg <= 1'b0;
        end else if (!regs[hbi_pkg::CONFIG_ADDR][hbi_pkg::CFG_TIMER_BIT] || in_reset) begin
            timer_reg     <= regs[hbi_pkg::TIMER_LOAD_ADDR];
            timer_pin_reg <= 1'b0;
        end else if (timer_zero) begin
            timer_reg     <= regs[hbi_pkg::TIMER_LOAD_ADDR];  // [RQ19]
            timer_pin_reg <= !timer_pin_reg;
        end else begin
            timer_reg <= timer_reg - 8'h01;                   // [RQ19]
        end
    end
    assign timer_zero = regs[hbi_pkg::CONFIG_ADDR][hbi_pkg::CFG_TIMER_BIT] && !in_reset
                        && (timer_reg == 8'h00);

    // Pending and in-service flags; a set in the same cycle as its clear wins.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            pending_flag    <= 1'b0;
            in_service_flag <= 1'b0;
        end else if (strobe_reset || in_reset) begin
            pending_flag    <= 1'b0;
            in_service_flag <= 1'b0;
        end else begin
            if (timer_zero) begin
                pending_flag <= 1'b1;
            end else if (acc.wr && acc.addr == hbi_pkg::COMMAND_ADDR
                         && acc.data[hbi_pkg::CMD_CLR_PEND]) begin
                pending_flag <= 1'b0;
            end
            if (win) begin
                in_service_flag <= 1'b1;                      // [RQ10] [RQ17]
            end else if (acc.wr && acc.addr == hbi_pkg::COMMAND_ADDR
                         && acc.data[hbi_pkg::CMD_CLR_SERV]) begin
                in_service_flag <= 1'b0;
            end
        end
    end

    // Bus driver: vector on a won acknowledge, register on a mapped read,
    // released when the strobe rises. A lost acknowledge leaves the bus alone.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_BUS_LINES <= 8'h00;
            O_BUS_OE    <= 1'b0;
        end else if (strobe_reset || strobe_idle) begin
            O_BUS_OE <= 1'b0;
        end else if (win) begin
            O_BUS_LINES <= regs[hbi_pkg::VECTOR_ADDR];        // [RQ10] [RQ17]
            O_BUS_OE    <= 1'b1;
        end else if (acc.rd && exists) begin
            O_BUS_LINES <= rdata;                             // [RQ6] [RQ13]
            O_BUS_OE    <= 1'b1;
        end
    end

    // Interrupt request pin and daisy chain output, both registered.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_IRQ_N            <= 1'b0;
            O_IRQ_OE           <= 1'b0;
            O_CHAIN_ENABLE_OUT <= 1'b0;
        end else begin
            O_IRQ_N  <= 1'b0;
            O_IRQ_OE <= pending_flag && !in_reset
                        && regs[hbi_pkg::MASTER_CTRL_ADDR][hbi_pkg::MC_ENABLE_BIT]; // [RQ8]
            O_CHAIN_ENABLE_OUT <= chain_in && !in_service_flag
                                  && !(ack_active && pending_flag);                 // [RQ7] [RQ9]
        end
    end

    // Port pins: general data, the timer on second port line 0 and the request
    // on handshake line 3. Every pin is released while in reset.
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_FIRST_PORT_LINES     <= 8'h00;
            O_FIRST_PORT_OE        <= 8'h00;
            O_SECOND_PORT_LINES    <= 8'h00;
            O_SECOND_PORT_OE       <= 8'h00;
            O_HANDSHAKE_PORT_LINES <= 4'h0;
            O_HANDSHAKE_PORT_OE    <= 4'h0;
        end else begin
            O_FIRST_PORT_LINES  <= regs[hbi_pkg::FIRST_DATA_ADDR];
            O_FIRST_PORT_OE     <= in_reset ? 8'h00 : regs[hbi_pkg::FIRST_DIR_ADDR];
            O_SECOND_PORT_LINES <= regs[hbi_pkg::SECOND_DATA_ADDR];
            O_SECOND_PORT_OE    <= in_reset ? 8'h00 : regs[hbi_pkg::SECOND_DIR_ADDR];
            O_HANDSHAKE_PORT_LINES <= regs[hbi_pkg::HS_DATA_ADDR][3:0];
            O_HANDSHAKE_PORT_OE <= in_reset ? 4'h0 : regs[hbi_pkg::HS_DIR_ADDR][3:0];
            if (regs[hbi_pkg::CONFIG_ADDR][hbi_pkg::CFG_TMR_PIN]) begin
                O_SECOND_PORT_LINES[0] <= timer_pin_reg;      // [RQ21]
            end
            if (regs[hbi_pkg::CONFIG_ADDR][hbi_pkg::CFG_HS_REQ]) begin
                O_HANDSHAKE_PORT_LINES[3] <= pending_flag && !in_service_flag; // [RQ20] [RQ18]
            end
        end
    end

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);

    chk_irq_drive: assert property (pending_flag && !in_reset  // [RQ8]
        && regs[hbi_pkg::MASTER_CTRL_ADDR][hbi_pkg::MC_ENABLE_BIT] |=> O_IRQ_OE)
        else $error("request pin not pulled while pending and enabled");
    chk_chain_block: assert property (ack_active && pending_flag |=> !O_CHAIN_ENABLE_OUT) // [RQ9]
        else $error("chain output high during acknowledge with pending set");
    chk_chain_pass: assert property (chain_in && !in_service_flag && !ack_active // [RQ7]
        |=> O_CHAIN_ENABLE_OUT)
        else $error("chain output low although nothing blocks it");
    chk_vector_out: assert property (win && !strobe_reset  // [RQ10]
        |=> O_BUS_OE && O_BUS_LINES == $past(regs[hbi_pkg::VECTOR_ADDR]))
        else $error("vector not driven after a won acknowledge");
    chk_serv_set: assert property (win |=> in_service_flag ##1 !O_CHAIN_ENABLE_OUT) // [RQ17]
        else $error("in-service flag or chain block missing after acknowledge");
    chk_mux_reset: assert property (muxed && !as_n && !ds_n |=> in_reset) // [RQ4]
        else $error("both muxed strobes low did not reset");
    chk_rw_reset: assert property (!muxed && !rd_n && !wr_n |=> in_reset) // [RQ12]
        else $error("read and write low together did not reset");
    chk_ptr_step: assert property (ptr_load && !strobe_reset  // [RQ23]
        |=> state_reg == hbi_pkg::ST_TARGET && ptr_reg == $past(acc.data[5:0]))
        else $error("pointer step not taken");
    chk_lost_ack: assert property (acc.ack && !win && !O_BUS_OE // [RQ25]
        |=> !O_BUS_OE && $stable(in_service_flag))
        else $error("losing device touched bus or flags");
    chk_bus_release: assert property (O_BUS_OE && strobe_idle |=> !O_BUS_OE) // [RQ6]
        else $error("bus not released after strobe");

    cov_won_ack: cover property (win ##1 O_BUS_OE);
    cov_ctrl_pair: cover property (ptr_load ##[1:40] (acc.rd && ctrl_sel));
    cov_timer_irq: cover property (timer_zero ##1 pending_flag ##1 O_IRQ_OE);
endmodule

`default_nettype wire

// ===== src/hbi_pkg.sv
// How it works
// [RQ1] Muxed: latch address, select, acknowledge during strobe.
// [RQ2] Muxed: data strobe times each transfer.
// [RQ3] Muxed: direction high reads, low writes.
// [RQ4] Both muxed strobes low resets device.
// [RQ5] Muxed: six latched address bits pick register.
// [RQ6] Muxed read drives register; unmapped stays released.
// [RQ7] Chain out high only when allowed.
// [RQ8] Request pin pulled low when pending, enabled.
// [RQ9] Acknowledge with pending forces chain out low.
// [RQ10] Muxed acknowledge: vector out, set in-service.
// [RQ11] Chip select low enables non-muxed access.
// [RQ12] Read and write both low resets device.
// [RQ13] Non-muxed read drives chosen register.
// [RQ14] Non-muxed write stores at write strobe fall.
// [RQ15] Host spaces accesses three clocks apart.
// [RQ16] Host keeps acknowledge synchronous and stable.
// [RQ17] Non-muxed acknowledge: vector, in-service on read.
// [RQ18] Request and wait change on clock.
// [RQ19] Control logic and timer use peripheral clock.
// [RQ20] Handshake lines: request line or general port.
// [RQ21] Second port: timer output or general port.
// [RQ22] Two address lines map data and control.
// [RQ23] Control access: pointer write, then register.
// [RQ24] Alignment bit chooses which bus bits decode.
// [RQ25] Losing acknowledge keeps bus released, flags unchanged.
package hbi_pkg;

    // Register offsets inside the 64-entry control space.
    localparam logic [5:0] MASTER_CTRL_ADDR = 6'h00;
    localparam logic [5:0] CONFIG_ADDR      = 6'h01;
    localparam logic [5:0] VECTOR_ADDR      = 6'h02;
    localparam logic [5:0] HS_DIR_ADDR      = 6'h06;
    localparam logic [5:0] COMMAND_ADDR     = 6'h08;
    localparam logic [5:0] FIRST_DATA_ADDR  = 6'h0d;
    localparam logic [5:0] SECOND_DATA_ADDR = 6'h0e;
    localparam logic [5:0] HS_DATA_ADDR     = 6'h0f;
    localparam logic [5:0] TIMER_LOAD_ADDR  = 6'h16;
    localparam logic [5:0] FIRST_DIR_ADDR   = 6'h23;
    localparam logic [5:0] SECOND_DIR_ADDR  = 6'h2b;

    // Field positions.
    localparam int MC_RESET_BIT   = 0;
    localparam int MC_ALIGN_BIT   = 1;
    localparam int MC_ENABLE_BIT  = 7;
    localparam int CFG_TIMER_BIT  = 0;
    localparam int CFG_TMR_PIN    = 1;
    localparam int CFG_HS_REQ     = 2;
    localparam int CMD_CLR_PEND   = 0;
    localparam int CMD_CLR_SERV   = 1;

    // Reset values and fixed answers.
    localparam logic [7:0] REG_RESET_VAL  = 8'h00;
    localparam logic [7:0] MC_RESET_VAL   = 8'h01;
    localparam logic [7:0] RESET_READ_VAL = 8'h01;

    // Non-muxed address line codes.
    localparam logic [1:0] SEL_HS     = 2'h0;
    localparam logic [1:0] SEL_SECOND = 2'h1;
    localparam logic [1:0] SEL_FIRST  = 2'h2;
    localparam logic [1:0] SEL_CTRL   = 2'h3;

    // Two-step control access states.
    typedef enum logic {ST_POINTER, ST_TARGET} hbi_state_t;

    // One decoded access, from either bus variant.
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       ack;
        logic [5:0] addr;
        logic [7:0] data;
    } hbi_access_t;

endpackage

// ===== tb/hbi_far_model.sv
`timescale 1ns/1ps
`default_nettype none

// Far side of the host port: the pulled-up request wire and an upper chain neighbour.
module hbi_far_model (
    input  wire logic i_irq_oe,
    input  wire logic i_irq_level,
    input  wire logic i_upper_busy,
    output var  logic o_irq_n,
    output var  logic o_chain_in
);
    // The wire has a pull-up, so it reads high unless some device pulls it low.
    always_comb o_irq_n = i_irq_oe ? i_irq_level : 1'b1;
    // A busy upper device blocks everyone below it on the chain.
    always_comb o_chain_in = !i_upper_busy;
endmodule

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clk = 0, rst_n = 0, mux = 0, as_n = 1, ds_n = 1, rhi = 0, sl_n = 1, sh = 0;
    logic rd_n = 1, wr_n = 1, cs_n = 1, ack_n = 1, busy = 0;
    logic [1:0] addr = 0;
    logic [7:0] bus_in = 0, bus_out, pa = 8'ha5, pb = 8'h3c;
    logic bus_oe, irq_oe, irq_n, ch_in, ch_out, irq_lv, t;
    logic [7:0] fl, fo, so, sbo;
    logic [3:0] ho;
    int fails = 0, tests_run = 0, cyc = 0, i;
    // Table rows: control offset and the value written then read back.
    logic [5:0] offs [4] = '{6'h02, 6'h16, 6'h23, 6'h2b};
    logic [7:0] vals [4] = '{8'h5a, 8'h03, 8'hf0, 8'h0f};

    hbi_host_bus uut (.I_CLK(clk), .I_RESET_N(rst_n), .I_MUXED_MODE(mux),
        .I_ADDR_STROBE_N(as_n), .I_DATA_STROBE_N(ds_n), .I_READ_HIGH(rhi),
        .I_SELECT_LOW_N(sl_n), .I_SELECT_HIGH(sh), .I_RD_N(rd_n), .I_WR_N(wr_n),
        .I_CHIP_SEL_N(cs_n), .I_ADDR(addr), .I_VECTOR_ACK_IN_N(ack_n),
        .I_CHAIN_ENABLE_IN(ch_in), .I_BUS_LINES(bus_in), .O_BUS_LINES(bus_out),
        .O_BUS_OE(bus_oe), .I_IRQ_N(irq_n), .O_IRQ_N(irq_lv), .O_IRQ_OE(irq_oe),
        .O_CHAIN_ENABLE_OUT(ch_out), .I_FIRST_PORT_LINES(pa), .O_FIRST_PORT_LINES(fl),
        .O_FIRST_PORT_OE(fo), .I_SECOND_PORT_LINES(pb), .O_SECOND_PORT_LINES(so),
        .O_SECOND_PORT_OE(sbo), .I_HANDSHAKE_PORT_LINES(4'h9), .O_HANDSHAKE_PORT_LINES(ho),
        .O_HANDSHAKE_PORT_OE());
    hbi_far_model far (.i_irq_oe(irq_oe), .i_irq_level(irq_lv), .i_upper_busy(busy),
        .o_irq_n(irq_n), .o_chain_in(ch_in));

    initial forever #25 clk = ~clk;
    // A hung handshake must not stall the run, so cycles are capped.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fails++;
            wrap_up();
        end
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Separate-strobe read; strobes are held until the drive shows, then spaced out.
    task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic m);
        int k;
        idle(1); addr = a; cs_n = 0; rd_n = 0;
        for (k = 0; k < 10 && bus_oe !== 1'b1; k++) idle(1);
        chk("drive", {7'h0, m}, {7'h0, bus_oe});
        if (m) chk("data", e, bus_out);
        rd_n = 1; cs_n = 1; idle(8);
    endtask
    // Spacing of eight clocks keeps well past the three-clock gap.
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        idle(1); addr = a; bus_in = d; cs_n = 0; wr_n = 0;
        idle(8); wr_n = 1; cs_n = 1; idle(8);
    endtask
    task automatic wreg(input logic [5:0] o, input logic [7:0] d);
        wr(2'h3, {2'h0, o}); wr(2'h3, d);
    endtask
    task automatic rreg(input logic [5:0] o, input logic [7:0] e, input logic m);
        wr(2'h3, {2'h0, o}); rd(2'h3, e, m);
    endtask
    // Multiplexed access: address phase under the address strobe, then the data strobe.
    task automatic macc(input logic [7:0] a, input logic w, input logic [7:0] d,
                        input logic [7:0] e, input logic m);
        int k;
        idle(1); bus_in = a; sl_n = 0; sh = 1; as_n = 0; idle(6); as_n = 1; idle(2);
        bus_in = d; rhi = !w; ds_n = 0;
        for (k = 0; k < 10 && bus_oe !== 1'b1; k++) idle(1);
        chk("mux drive", {7'h0, m}, {7'h0, bus_oe});
        if (m) chk("mux data", e, bus_out);
        ds_n = 1; sl_n = 1; sh = 0; idle(8);
    endtask
    task automatic wrap_up;
        $display("counts %0d checks %0d mismatches", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        idle(16); rst_n = 1; idle(6);
        chk("chain", 8'h1, {7'h0, ch_out});
        rd(2'h3, hbi_pkg::RESET_READ_VAL, 1'b1);
        wr(2'h3, 8'h00); wr(2'h3, 8'h00); rd(2'h3, 8'h00, 1'b1);
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            wreg(offs[i], vals[i]); rreg(offs[i], vals[i], 1'b1);
        end
        rd(2'h3, vals[3], 1'b1);
        rreg(6'h3f, 8'h00, 1'b0);
        rd(2'h2, pa, 1'b1); rd(2'h1, pb, 1'b1);
        wr(2'h2, 8'h96); chk("first out", 8'h96, fl);
        chk("first dir", 8'hf0, fo); chk("second dir", 8'h0f, sbo);
        $display("test registers done");
        wreg(hbi_pkg::MASTER_CTRL_ADDR, 8'h80); wreg(hbi_pkg::CONFIG_ADDR, 8'h07);
        for (i = 0; i < 100 && irq_n !== 1'b0; i++) idle(1);
        chk("request", 8'h0, {7'h0, irq_n});
        chk("hs request", 8'h1, {7'h0, ho[3]});
        t = so[0]; idle(4); chk("timer pin", {7'h0, !t}, {7'h0, so[0]});
        busy = 1; ack_n = 0; idle(6); rd(2'h3, 8'h00, 1'b0);
        busy = 0; idle(6); chk("chain", 8'h0, {7'h0, ch_out});
        rd(2'h3, vals[0], 1'b1); ack_n = 1; idle(6);
        chk("chain", 8'h0, {7'h0, ch_out});
        chk("hs request", 8'h0, {7'h0, ho[3]});
        $display("test acknowledge done");
        rd_n = 0; wr_n = 0; idle(8); rd_n = 1; wr_n = 1; idle(8);
        chk("request", 8'h1, {7'h0, irq_n});
        chk("first dir", 8'h00, fo);
        rd(2'h3, hbi_pkg::RESET_READ_VAL, 1'b1);
        mux = 1; idle(8);
        macc(8'h00, 1'b1, 8'h00, 8'h00, 1'b0);
        macc(8'h04, 1'b1, 8'h3c, 8'h00, 1'b0);
        macc(8'h04, 1'b0, 8'h00, 8'h3c, 1'b1);
        macc(8'h7e, 1'b0, 8'h00, 8'h00, 1'b0);
        macc(8'h00, 1'b1, 8'h02, 8'h00, 1'b0);
        macc(8'h02, 1'b0, 8'h00, 8'h3c, 1'b1);
        macc(8'h01, 1'b1, 8'h01, 8'h00, 1'b0);
        ack_n = 0; macc(8'h00, 1'b0, 8'h00, 8'h3c, 1'b1); ack_n = 1;
        as_n = 0; ds_n = 0; idle(8); as_n = 1; ds_n = 1; idle(8);
        macc(8'h02, 1'b0, 8'h00, hbi_pkg::RESET_READ_VAL, 1'b1);
        $display("test multiplexed done");
        wrap_up();
    end
endmodule

`default_nettype wire
